/* rtl/system_clock_source_control.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Unlock bit set enables protected clock writes
// - Unlock bit cleared disables them again
// - Slow oscillator stop bit 0 runs it
// - Pin switch 1 gives crystal pins oscillator
// - Crystal stop bit 0 runs crystal oscillator
// - First select 0 picks crystal or on-chip
// - Second select 0 picks crystal clock
module system_clock_source_control
  import clk_src_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [clk_src_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [clk_src_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic slowOscRun,
  output logic crystalOscRun,
  output logic crystalPinsOsc,
  output logic [1:0] sysclkSource
);
  import clk_src_pkg::*;

  // Register offsets decode
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    if (a == OFS_PROTECT || a == OFS_MODE_FIRST) begin
      isMapped = 1'b1;
    end else if (a == OFS_MODE_SECOND || a == OFS_STOP_DET) begin
      isMapped = 1'b1;
    end else if (a == OFS_STATUS) begin
      isMapped = 1'b1;
    end else if (a >= OFS_AUX_BASE && a < OFS_STATUS && a[1:0] == 2'h0) begin
      isMapped = 1'b1;
    end else begin
      isMapped = 1'b0;
    end
  endfunction

  // Aux slot index from an address inside the aux window
  function automatic logic [2:0] auxIdx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_AUX_BASE;
    auxIdx = d[4:2];
  endfunction

  logic wrEn; // One-cycle commit from the bus port
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic wrErr;
  logic rdErr;
  logic unlock_ff; // Write gate for the clock group
  logic [7:0] modeFirst_ff;
  logic [7:0] modeSecond_ff;
  logic [7:0] stopDet_ff;
  logic [7:0] aux_ff [AUX_COUNT]; // Third mode and fast osc registers
  logic slowOscRun_ff;
  logic crystalOscRun_ff;
  logic crystalPinsOsc_ff;
  logic [1:0] sysclkSource_ff;
  logic laneWr; // Low byte lane written
  logic openWr; // Protected write allowed
  logic [1:0] nxt_source;

  axil_slave_port u_bus (
    .clock(clock),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  assign laneWr = wrEn && wrStrb[0];
  // Locked writes still answer OKAY, they just do nothing
  assign openWr = laneWr && unlock_ff;
  assign wrErr = !isMapped(wrAddr);
  assign rdErr = !isMapped(rdAddr);

  // Protect register, itself never protected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unlock_ff <= RST_PROTECT[BIT_UNLOCK];
    end else if (laneWr && wrAddr == OFS_PROTECT) begin
      unlock_ff <= wrData[BIT_UNLOCK];
    end
  end

  // First mode register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modeFirst_ff <= RST_MODE_FIRST;
    end else if (openWr && wrAddr == OFS_MODE_FIRST) begin
      modeFirst_ff <= wrData[7:0];
    end
  end

  // Second mode register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modeSecond_ff <= RST_MODE_SECOND;
    end else if (openWr && wrAddr == OFS_MODE_SECOND) begin
      modeSecond_ff <= wrData[7:0];
    end
  end

  // Oscillation stop detection register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stopDet_ff <= RST_STOP_DET;
    end else if (openWr && wrAddr == OFS_STOP_DET) begin
      stopDet_ff <= wrData[7:0];
    end
  end

  // Third mode and fast oscillator registers, storage only here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < AUX_COUNT; i++) begin
        aux_ff[i] <= RST_AUX;
      end
    end else if (openWr && wrAddr >= OFS_AUX_BASE && wrAddr < OFS_STATUS) begin
      aux_ff[auxIdx(wrAddr)] <= wrData[7:0];
    end
  end

  // Oscillator enables and pin routing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slowOscRun_ff <= 1'b0;
      crystalOscRun_ff <= 1'b0;
      crystalPinsOsc_ff <= 1'b0;
    end else begin
      slowOscRun_ff <= !modeSecond_ff[BIT_SLOW_STOP];
      crystalPinsOsc_ff <= modeSecond_ff[BIT_PIN_SWITCH];
      crystalOscRun_ff <= !modeFirst_ff[BIT_XTAL_STOP];
    end
  end

  // Source select; no stability check, software owns the wait
  always_comb begin
    if (modeFirst_ff[BIT_FIRST_SEL]) begin
      nxt_source = SRC_ALT;
    end else if (!stopDet_ff[BIT_SECOND_SEL]) begin
      nxt_source = SRC_CRYSTAL;
    end else begin
      nxt_source = SRC_ONCHIP;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sysclkSource_ff <= SRC_ONCHIP;
    end else begin
      sysclkSource_ff <= nxt_source;
    end
  end

  // Read mux, unused bits read zero
  always_comb begin
    rdData = '0;
    if (rdAddr == OFS_PROTECT) begin
      rdData[7:0] = {7'h00, unlock_ff} & PROTECT_MASK;
    end else if (rdAddr == OFS_MODE_FIRST) begin
      rdData[7:0] = modeFirst_ff;
    end else if (rdAddr == OFS_MODE_SECOND) begin
      rdData[7:0] = modeSecond_ff;
    end else if (rdAddr == OFS_STOP_DET) begin
      rdData[7:0] = stopDet_ff;
    end else if (rdAddr == OFS_STATUS) begin
      rdData[4:0] = {sysclkSource_ff, crystalPinsOsc_ff, crystalOscRun_ff, slowOscRun_ff};
    end else if (isMapped(rdAddr)) begin
      rdData[7:0] = aux_ff[auxIdx(rdAddr)];
    end
  end

  assign slowOscRun = slowOscRun_ff;
  assign crystalOscRun = crystalOscRun_ff;
  assign crystalPinsOsc = crystalPinsOsc_ff;
  assign sysclkSource = sysclkSource_ff;

  // Checks
  sequence s_openWr;
    laneWr && unlock_ff;
  endsequence

  sequence s_lockedWr;
    laneWr && !unlock_ff;
  endsequence

  property p_unlockWrite;
    @(posedge clock) disable iff (!rst_n)
      s_openWr and (wrAddr == OFS_MODE_FIRST) |=> modeFirst_ff == $past(wrData[7:0]);
  endproperty
  a_unlockWrite: assert property (p_unlockWrite) else $error("open write lost");

  property p_relock;
    @(posedge clock) disable iff (!rst_n)
      laneWr && wrAddr == OFS_PROTECT && !wrData[BIT_UNLOCK] |=> !unlock_ff;
  endproperty
  a_relock: assert property (p_relock) else $error("unlock not cleared");

  property p_lockedHold;
    @(posedge clock) disable iff (!rst_n)
      s_lockedWr |=> $stable(modeFirst_ff) && $stable(modeSecond_ff) && $stable(stopDet_ff);
  endproperty
  a_lockedHold: assert property (p_lockedHold) else $error("locked write took");

  property p_slowStop;
    @(posedge clock) disable iff (!rst_n)
      s_openWr and (wrAddr == OFS_MODE_SECOND) |-> ##2 slowOscRun == !$past(wrData[4], 2);
  endproperty
  a_slowStop: assert property (p_slowStop) else $error("slow osc wrong");

  property p_pinSwitch;
    @(posedge clock) disable iff (!rst_n)
      s_openWr and (wrAddr == OFS_MODE_SECOND) |-> ##2 crystalPinsOsc == $past(wrData[3], 2);
  endproperty
  a_pinSwitch: assert property (p_pinSwitch) else $error("pin routing wrong");

  property p_xtalRun;
    @(posedge clock) disable iff (!rst_n)
      s_openWr and (wrAddr == OFS_MODE_FIRST) |-> ##2 crystalOscRun == !$past(wrData[5], 2);
  endproperty
  a_xtalRun: assert property (p_xtalRun) else $error("crystal run wrong");

  property p_firstSel;
    @(posedge clock) disable iff (!rst_n)
      !modeFirst_ff[BIT_FIRST_SEL] |=> sysclkSource != SRC_ALT;
  endproperty
  a_firstSel: assert property (p_firstSel) else $error("alt source chosen");

  property p_secondSel;
    @(posedge clock) disable iff (!rst_n)
      !modeFirst_ff[BIT_FIRST_SEL] && !stopDet_ff[BIT_SECOND_SEL] |=> sysclkSource == SRC_CRYSTAL;
  endproperty
  a_secondSel: assert property (p_secondSel) else $error("crystal not chosen");
endmodule

/* rtl/clk_src_pkg.sv */
package clk_src_pkg;
  // Register byte offsets, one aligned word each
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PROTECT = 8'h00;
  localparam logic [7:0] OFS_MODE_FIRST = 8'h04;
  localparam logic [7:0] OFS_MODE_SECOND = 8'h08;
  localparam logic [7:0] OFS_STOP_DET = 8'h0c;
  // Third mode, fast osc control a, trim a, control b, trim b
  localparam logic [7:0] OFS_AUX_BASE = 8'h10;
  localparam int AUX_COUNT = 5;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // Field positions
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_PIN_SWITCH = 3;
  localparam int BIT_SLOW_STOP = 4;
  localparam int BIT_XTAL_STOP = 5;
  localparam int BIT_FIRST_SEL = 7;
  localparam int BIT_SECOND_SEL = 2;
  // Reset values
  localparam logic [7:0] RST_PROTECT = 8'h00;
  localparam logic [7:0] RST_MODE_FIRST = 8'h20;
  localparam logic [7:0] RST_MODE_SECOND = 8'h00;
  localparam logic [7:0] RST_STOP_DET = 8'h04;
  localparam logic [7:0] RST_AUX = 8'h00;
  // Only the unlock bit is stored in the protect register
  localparam logic [7:0] PROTECT_MASK = 8'h01;
  // System clock source codes
  localparam logic [1:0] SRC_CRYSTAL = 2'h0;
  localparam logic [1:0] SRC_ONCHIP = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/axil_slave_port.sv */
`timescale 1ns/1ps
module axil_slave_port
  import clk_src_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [clk_src_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [clk_src_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrEn,
  output logic [clk_src_pkg::ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [clk_src_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awready_ff; // Address slot free
  logic wready_ff; // Data slot free
  logic awHeld_ff;
  logic wHeld_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [ADDR_W-1:0] wrAddr_ff;
  logic [31:0] wrData_ff;
  logic [3:0] wrStrb_ff;
  logic awTake;
  logic wTake;
  logic arTake;

  assign awTake = awvalid && awready_ff;
  assign wTake = wvalid && wready_ff;
  assign arTake = arvalid && arready_ff;
  // Commit once both halves are in; the response slot is then free
  assign wrEn = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign wrAddr = wrAddr_ff;
  assign wrData = wrData_ff;
  assign wrStrb = wrStrb_ff;
  // Read decode looks straight at the offered address
  assign rdAddr = araddr;

  // Address channel, either order with data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      awHeld_ff <= 1'b0;
      wrAddr_ff <= '0;
    end else if (awTake) begin
      awready_ff <= 1'b0;
      awHeld_ff <= 1'b1;
      wrAddr_ff <= awaddr;
    end else begin
      if (wrEn) awHeld_ff <= 1'b0;
      // Reopen only after the response is gone: one write in flight
      if (bvalid_ff && bready) awready_ff <= 1'b1;
    end
  end

  // Data channel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wready_ff <= 1'b1;
      wHeld_ff <= 1'b0;
      wrData_ff <= '0;
      wrStrb_ff <= '0;
    end else if (wTake) begin
      wready_ff <= 1'b0;
      wHeld_ff <= 1'b1;
      wrData_ff <= wdata;
      wrStrb_ff <= wstrb;
    end else begin
      if (wrEn) wHeld_ff <= 1'b0;
      if (bvalid_ff && bready) wready_ff <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wrEn) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wrErr ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel, data captured at the address edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (arTake) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= rdErr ? RESP_SLVERR : RESP_OKAY;
      rdata_ff <= rdData;
    end else if (rvalid_ff && rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import clk_src_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic slowOscRun;
  logic crystalOscRun;
  logic crystalPinsOsc;
  logic [1:0] sysclkSource;
  int mismatches = 0; // Failed compares
  int comparisons = 0; // All compares
  int cycles = 0; // Hang guard
  logic [31:0] rd; // Last read data
  logic [1:0] rsp; // Last response

  system_clock_source_control dut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .slowOscRun(slowOscRun), .crystalOscRun(crystalOscRun),
    .crystalPinsOsc(crystalPinsOsc), .sysclkSource(sysclkSource));

  // 100 MHz clock
  always #5 clock = ~clock;

  // Verdict and end of run
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs far fewer cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data offered together, each released at its own take
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && awready) begin
        awDone = 1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    // Let an edge pass so a following call never re-drives bready in this step
    @(posedge clock);
  endtask

  task automatic axiRead(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    // Same spacing as writes: rready is never assigned twice in one step
    @(posedge clock);
  endtask

  // Read back a register; the response must be OKAY
  task automatic expectReg(input string what, input logic [7:0] a, input logic [7:0] exp);
    axiRead(a);
    check(what, rd, {24'h0, exp});
    check("read resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // Outputs land one edge after the register, so let them settle
  task automatic expectOuts(input logic slow, input logic xtal, input logic pins,
                            input logic [1:0] src);
    repeat (2) @(posedge clock);
    #1;
    check("slowOscRun", {31'h0, slowOscRun}, {31'h0, slow});
    check("crystalOscRun", {31'h0, crystalOscRun}, {31'h0, xtal});
    check("crystalPinsOsc", {31'h0, crystalPinsOsc}, {31'h0, pins});
    check("sysclkSource", {30'h0, sysclkSource}, {30'h0, src});
    @(posedge clock);
    expectReg("status", OFS_STATUS, {3'h0, src, pins, xtal, slow});
  endtask

  task automatic testReset();
    expectReg("protect", OFS_PROTECT, RST_PROTECT);
    expectReg("mode first", OFS_MODE_FIRST, RST_MODE_FIRST);
    expectReg("mode second", OFS_MODE_SECOND, RST_MODE_SECOND);
    expectReg("stop det", OFS_STOP_DET, RST_STOP_DET);
    expectOuts(1'b1, 1'b0, 1'b0, SRC_ONCHIP);
  endtask

  // Writes while locked answer OKAY and change nothing
  // Aux slots keep reset contents, or the pattern stored while open
  task automatic testLocked(input logic [7:0] prot, input bit opened);
    axiWrite(OFS_MODE_SECOND, 8'h18);
    check("locked resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    axiWrite(OFS_MODE_FIRST, 8'ha0);
    axiWrite(OFS_STOP_DET, 8'h00);
    expectReg("stop det locked", OFS_STOP_DET, RST_STOP_DET);
    for (int i = 0; i < AUX_COUNT; i++) begin
      axiWrite(OFS_AUX_BASE + 8'(4 * i), 8'h5a);
      expectReg("aux locked", OFS_AUX_BASE + 8'(4 * i),
                opened ? 8'(8'h30 + i) : RST_AUX);
    end
    expectReg("protect", OFS_PROTECT, prot);
  endtask

  task automatic testUnlockPins();
    axiWrite(OFS_PROTECT, 8'hff);
    expectReg("unlock", OFS_PROTECT, 8'h01);
    axiWrite(OFS_MODE_SECOND, 8'h18);
    expectReg("mode second", OFS_MODE_SECOND, 8'h18);
    expectOuts(1'b0, 1'b0, 1'b1, SRC_ONCHIP);
    axiWrite(OFS_MODE_SECOND, 8'h08);
    expectOuts(1'b1, 1'b0, 1'b1, SRC_ONCHIP);
    // Low lane strobe off: the write must not land
    axiWrite(OFS_MODE_SECOND, 8'h10, 4'he);
    expectReg("mode second no lane", OFS_MODE_SECOND, 8'h08);
    for (int i = 0; i < AUX_COUNT; i++) begin
      axiWrite(OFS_AUX_BASE + 8'(4 * i), 8'(8'h30 + i));
      expectReg("aux open", OFS_AUX_BASE + 8'(4 * i), 8'(8'h30 + i));
    end
  endtask

  task automatic testSelect();
    axiWrite(OFS_MODE_FIRST, 8'h00);
    expectOuts(1'b1, 1'b1, 1'b1, SRC_ONCHIP);
    repeat (50) @(posedge clock);
    axiWrite(OFS_STOP_DET, 8'h00);
    expectOuts(1'b1, 1'b1, 1'b1, SRC_CRYSTAL);
    axiWrite(OFS_MODE_FIRST, 8'h80);
    expectOuts(1'b1, 1'b1, 1'b1, SRC_ALT);
    axiWrite(OFS_MODE_FIRST, 8'h00);
    axiWrite(OFS_STOP_DET, 8'h04);
    expectOuts(1'b1, 1'b1, 1'b1, SRC_ONCHIP);
    axiWrite(OFS_MODE_FIRST, 8'h20);
    expectOuts(1'b1, 1'b0, 1'b1, SRC_ONCHIP);
    axiWrite(OFS_MODE_FIRST, 8'h00);
  endtask

  // Relocking must freeze every protected register again
  task automatic testRelock();
    axiWrite(OFS_PROTECT, 8'h00);
    expectReg("relock", OFS_PROTECT, 8'h00);
    testLocked(8'h00, 1'b1);
    expectReg("mode second kept", OFS_MODE_SECOND, 8'h08);
    expectReg("mode first kept", OFS_MODE_FIRST, 8'h00);
    expectOuts(1'b1, 1'b1, 1'b1, SRC_ONCHIP);
  endtask

  task automatic testUnmapped();
    axiWrite(8'h30, 8'hff);
    check("unmapped write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    axiRead(8'h30);
    check("unmapped read resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    check("unmapped read data", rd, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    testReset();
    testLocked(8'h00, 1'b0);
    expectOuts(1'b1, 1'b0, 1'b0, SRC_ONCHIP);
    testUnlockPins();
    testSelect();
    testRelock();
    testUnmapped();
    stop_test();
  end
endmodule
